// ===== src/pmc_pkg.sv
package pmc_pkg;

    // Register byte addresses
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_RESET_CAUSE = 12'h008;
    localparam logic [11:0] REG_IRQ_STATUS = 12'h00c;
    localparam logic [11:0] REG_IRQ_MASK = 12'h010;
    localparam logic [11:0] REG_WAKE_PIN_EN = 12'h014;
    localparam logic [11:0] REG_CLK_CFG = 12'h018;
    localparam logic [11:0] REG_WDT_CTRL = 12'h01c;
    localparam logic [11:0] REG_WDT_LOAD = 12'h020;
    localparam logic [11:0] REG_WDT_COUNT = 12'h024;

    // Mode request codes in the control register
    localparam logic [1:0] REQ_IDLE = 2'h1;
    localparam logic [1:0] REQ_STANDBY = 2'h2;
    localparam logic [1:0] REQ_SHUTDOWN = 2'h3;
    localparam int REQ_W = 2;

    // Reset cause codes
    localparam logic [1:0] CAUSE_POR = 2'h0;
    localparam logic [1:0] CAUSE_PIN = 2'h1;
    localparam logic [1:0] CAUSE_SHDN_WAKE = 2'h2;

    // Interrupt status and mask bits
    localparam int IRQ_IDLE_WAKE = 0;
    localparam int IRQ_STBY_WAKE = 1;
    localparam int IRQ_WDT = 2;
    localparam int IRQ_W = 3;

    // Clock configuration bits
    localparam int CLK_FAST_XTAL = 0;
    localparam int CLK_SLOW_XTAL = 1;
    localparam int CLK_MED_STBY = 2;
    localparam int CLK_W = 3;

    // Watchdog control bit
    localparam int WDT_EN_BIT = 0;

    // Retention levels
    localparam logic [1:0] RET_NONE = 2'h0;
    localparam logic [1:0] RET_PARTIAL = 2'h1;
    localparam logic [1:0] RET_FULL = 2'h2;

    // Watchdog tick: fractional divider from the system clock
    localparam int SYS_CLK_KHZ = 40000;
    localparam int WDT_CLK_KHZ = 1500;
    localparam int ACC_W = 16;

    typedef enum logic [2:0] {
        MODE_ACTIVE,
        MODE_IDLE,
        MODE_STANDBY,
        MODE_SHUTDOWN,
        MODE_HELD
    } mode_t;

endpackage : pmc_pkg

// ===== src/watchdog_counter.sv
`timescale 1ns/1ps
module watchdog_counter #(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Control
    input wire logic clr_i,
    input wire logic en_set_i,
    input wire logic load_we_i,
    input wire logic [CNT_W-1:0] load_i,
    input wire logic pause_i,
    // Status
    output logic en_o,
    output logic [CNT_W-1:0] count_o,
    output logic expire_o
);
    import pmc_pkg::*;

    typedef struct packed {
        logic en;
        logic [CNT_W-1:0] load;
        logic [CNT_W-1:0] cnt;
        logic [ACC_W-1:0] acc;
        logic expire;
    } wdt_t;

    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(WDT_CLK_KHZ);
    localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(SYS_CLK_KHZ);

    wdt_t q, d;
    logic tick;

    always_comb begin
        d = q;
        d.expire = 1'b0;
        tick = 1'b0;
        if (clr_i) begin
            d = '0;
        end else begin
            // Enable is set-only so software cannot stop it, see R12
            if (en_set_i) begin
                d.en = 1'b1;
            end
            if (load_we_i) begin
                d.load = load_i;
                d.cnt = load_i;
            end else if (q.en && !pause_i) begin // see R13
                // Exact 1.5 MHz average tick rate, see R12
                if (q.acc + ACC_STEP >= ACC_MOD) begin
                    d.acc = q.acc + ACC_STEP - ACC_MOD;
                    tick = 1'b1;
                end else begin
                    d.acc = q.acc + ACC_STEP;
                end
                if (tick) begin
                    if (q.cnt == '0) begin
                        d.cnt = q.load;
                        d.expire = 1'b1;
                    end else begin
                        d.cnt = q.cnt - 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign en_o = q.en;
    assign count_o = q.cnt;
    assign expire_o = q.expire;

endmodule : watchdog_counter

// ===== src/power_mode_controller.sv
`timescale 1ns/1ps
// How it works
// R1: Active keeps CPU and enabled peripherals clocked
// R2: Idle stops CPU and memory clocks only
// R3: Any interrupt event wakes idle to active
// R4: Standby powers only always-on domain, SRAM retained
// R5: Only external, RTC or sensor events end standby
// R6: Standby wake keeps retained config and CPU context
// R7: All I/Os latched throughout standby
// R8: Shutdown removes all power, I/Os hold prior value
// R9: Enabled pin change in shutdown causes reset wake
// R10: Reset cause register tells shutdown, pin, power-on
// R11: Shutdown preserves only I/O latches and flash
// R12: Watchdog ticks at 1.5 MHz, cannot be stopped
// R13: Watchdog pauses in standby, debug halt; off in shutdown and held
// R14: Retention full active/idle, partial standby, else none
// R15: Medium clock on active/idle, optional standby, else off
// R16: Low-speed clock on except shutdown and reset held
// R17: Main fast clock on in active and idle only
// R18: Reset pin wake path enabled in every state
// R19: Software requests low modes; reset pin forces held
module power_mode_controller #(
    parameter int NPINS = 31,
    parameter int WDT_W = 32
) (
    // Clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [31:0] prdata_o,
    // Wake sources and debug halt
    input wire logic rst_pin_n_i,
    input wire logic irq_event_i,
    input wire logic ext_wake_i,
    input wire logic rtc_event_i,
    input wire logic sensor_event_i,
    input wire logic [NPINS-1:0] pin_i,
    input wire logic debug_halt_i,
    // I/O drive from the pin logic
    input wire logic [NPINS-1:0] io_out_i,
    output logic [NPINS-1:0] io_out_o,
    output logic io_latch_o,
    // Clock gates
    output logic cpu_clk_en_o,
    output logic mem_clk_en_o,
    output logic periph_clk_en_o,
    // Power domains
    output logic flash_pwr_o,
    output logic sram_pwr_o,
    output logic sram_ret_o,
    output logic periph_pwr_o,
    output logic always_on_domain_pwr_o,
    output logic sensor_pwr_o,
    output logic [1:0] reg_ret_o,
    output logic brownout_detector_en_o,
    // Clock sources and reset pin wake enable
    output logic main_fast_clock_en_o,
    output logic fast_crystal_osc_sel_o,
    output logic medium_speed_clock_en_o,
    output logic low_speed_clock_en_o,
    output logic slow_crystal_osc_sel_o,
    output logic reset_pin_wake_en_o,
    // Status
    output pmc_pkg::mode_t mode_o,
    output logic irq_o
);
    import pmc_pkg::*;

    typedef struct packed {
        mode_t mode;
        logic [1:0] cause;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_msk;
        logic [NPINS-1:0] wake_en;
        logic [CLK_W-1:0] clk_cfg;
        logic [NPINS-1:0] io;
        logic [NPINS-1:0] pin_snap;
        logic [31:0] rdata;
        logic rvalid;
        logic err;
    } st_t;

    st_t q, d;

    logic wr_done;
    logic rd_hit;
    logic [31:0] rd_val;
    logic [NPINS-1:0] pin_chg;
    logic wdt_clr;
    logic wdt_pause;
    logic wdt_en_set;
    logic wdt_load_we;
    logic wdt_en;
    logic [WDT_W-1:0] wdt_count;
    logic wdt_expire;
    logic [IRQ_W-1:0] irq_set;

    // Decoding shared by reads and writes
    function automatic logic is_reg(input logic [11:0] a,
        input logic [11:0] r);
        return a == r;
    endfunction : is_reg

    function automatic logic mapped(input logic [11:0] a);
        if (is_reg(a, REG_CTRL)) begin
            return 1'b1;
        end else if (is_reg(a, REG_STATUS)) begin
            return 1'b1;
        end else if (is_reg(a, REG_RESET_CAUSE)) begin
            return 1'b1;
        end else if (is_reg(a, REG_IRQ_STATUS)) begin
            return 1'b1;
        end else if (is_reg(a, REG_IRQ_MASK)) begin
            return 1'b1;
        end else if (is_reg(a, REG_WAKE_PIN_EN)) begin
            return 1'b1;
        end else if (is_reg(a, REG_CLK_CFG)) begin
            return 1'b1;
        end else if (is_reg(a, REG_WDT_CTRL)) begin
            return 1'b1;
        end else if (is_reg(a, REG_WDT_LOAD)) begin
            return 1'b1;
        end else if (is_reg(a, REG_WDT_COUNT)) begin
            return 1'b1;
        end
        return 1'b0;
    endfunction : mapped

    // Core supplies and fast clocks are up only while awake
    function automatic logic awake(input mode_t m);
        return m == MODE_ACTIVE || m == MODE_IDLE;
    endfunction : awake

    // Always-on domain drops only in shutdown and under reset
    function automatic logic aon_lost(input mode_t m);
        return m == MODE_SHUTDOWN || m == MODE_HELD;
    endfunction : aon_lost

    // Writes act at the access edge, the one that sees pready high
    assign wr_done = psel_i && penable_i && pwrite_i && q.rvalid;

    // Level change on a shutdown-wake pin since entry, see R9
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_pin
            assign pin_chg[gi] = q.wake_en[gi] &&
                (pin_i[gi] != q.pin_snap[gi]);
        end
    endgenerate

    always_comb begin
        rd_hit = 1'b1;
        if (is_reg(paddr_i, REG_CTRL)) begin
            rd_val = '0;
        end else if (is_reg(paddr_i, REG_STATUS)) begin
            rd_val = 32'(q.mode);
        end else if (is_reg(paddr_i, REG_RESET_CAUSE)) begin
            rd_val = 32'(q.cause); // see R10
        end else if (is_reg(paddr_i, REG_IRQ_STATUS)) begin
            rd_val = 32'(q.irq_st);
        end else if (is_reg(paddr_i, REG_IRQ_MASK)) begin
            rd_val = 32'(q.irq_msk);
        end else if (is_reg(paddr_i, REG_WAKE_PIN_EN)) begin
            rd_val = 32'(q.wake_en);
        end else if (is_reg(paddr_i, REG_CLK_CFG)) begin
            rd_val = 32'(q.clk_cfg);
        end else if (is_reg(paddr_i, REG_WDT_CTRL)) begin
            rd_val = 32'(wdt_en);
        end else if (is_reg(paddr_i, REG_WDT_COUNT)) begin
            rd_val = 32'(wdt_count);
        end else if (is_reg(paddr_i, REG_WDT_LOAD)) begin
            rd_val = '0;
        end else begin
            rd_val = '0;
            rd_hit = 1'b0;
        end
    end

    always_comb begin
        d = q;
        irq_set = '0;

        // Bus: capture read data one cycle ahead of pready
        d.rvalid = psel_i && !(penable_i && q.rvalid);
        if (psel_i) begin
            d.rdata = pwrite_i ? 32'h0000_0000 : rd_val;
            d.err = !rd_hit;
        end

        // I/Os follow the pin logic unless latched, see R7 R8
        if (awake(q.mode)) begin
            d.io = io_out_i;
            d.pin_snap = pin_i;
        end

        // Register writes
        if (wr_done && mapped(paddr_i)) begin
            if (is_reg(paddr_i, REG_IRQ_MASK)) begin
                d.irq_msk = pwdata_i[IRQ_W-1:0];
            end else if (is_reg(paddr_i, REG_WAKE_PIN_EN)) begin
                d.wake_en = pwdata_i[NPINS-1:0];
            end else if (is_reg(paddr_i, REG_CLK_CFG)) begin
                d.clk_cfg = pwdata_i[CLK_W-1:0];
            end else if (is_reg(paddr_i, REG_IRQ_STATUS)) begin
                d.irq_st = q.irq_st & ~pwdata_i[IRQ_W-1:0];
            end
        end

        // Mode sequencing
        case (q.mode)
            MODE_ACTIVE: begin
                if (wr_done && is_reg(paddr_i, REG_CTRL)) begin // see R19
                    case (pwdata_i[REQ_W-1:0])
                        REQ_IDLE: d.mode = MODE_IDLE;
                        REQ_STANDBY: d.mode = MODE_STANDBY;
                        REQ_SHUTDOWN: d.mode = MODE_SHUTDOWN;
                        default: d.mode = MODE_ACTIVE;
                    endcase
                end
            end
            MODE_IDLE: begin
                if (irq_event_i) begin // see R3
                    d.mode = MODE_ACTIVE;
                    irq_set[IRQ_IDLE_WAKE] = 1'b1;
                end
            end
            MODE_STANDBY: begin
                // Registers are kept, so the CPU resumes in place, see R6
                if (ext_wake_i || rtc_event_i ||
                    sensor_event_i) begin // see R5
                    d.mode = MODE_ACTIVE;
                    irq_set[IRQ_STBY_WAKE] = 1'b1;
                end
            end
            MODE_SHUTDOWN: begin
                if (|pin_chg) begin
                    // Wake acts as a reset: all but the latched I/Os go
                    d = '0; // see R9 R11
                    d.io = q.io;
                    d.cause = CAUSE_SHDN_WAKE; // see R10
                end
            end
            MODE_HELD: begin
                if (rst_pin_n_i) begin
                    d = '0; // see R11
                    d.cause = CAUSE_PIN; // see R10
                end
            end
            default: d.mode = MODE_ACTIVE;
        endcase

        if (wdt_expire) begin
            irq_set[IRQ_WDT] = 1'b1;
        end
        // A new event wins over a clear in the same cycle
        d.irq_st = d.irq_st | irq_set;

        // Reset pin overrides any request, held state loses all but the I/Os, see R19
        if (!rst_pin_n_i) begin
            d = '0;
            d.mode = MODE_HELD;
            d.io = q.io;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    // Watchdog control
    assign wdt_clr = aon_lost(q.mode); // see R13
    assign wdt_pause = q.mode == MODE_STANDBY || debug_halt_i; // see R13
    assign wdt_en_set = wr_done && is_reg(paddr_i, REG_WDT_CTRL) &&
        pwdata_i[WDT_EN_BIT];
    assign wdt_load_we = wr_done && is_reg(paddr_i, REG_WDT_LOAD);

    watchdog_counter #(
        .CNT_W(WDT_W)
    ) u_wdt (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .clr_i(wdt_clr),
        .en_set_i(wdt_en_set),
        .load_we_i(wdt_load_we),
        .load_i(pwdata_i[WDT_W-1:0]),
        .pause_i(wdt_pause),
        .en_o(wdt_en),
        .count_o(wdt_count),
        .expire_o(wdt_expire)
    );

    // Bus answers
    // No wait states; a low clock enable stretches the access
    assign pready_o = ce_i && psel_i && penable_i && q.rvalid;
    assign pslverr_o = pready_o && q.err;
    assign prdata_o = q.rdata;

    // Mode decode of gates and supplies
    assign cpu_clk_en_o = q.mode == MODE_ACTIVE; // see R1 R2
    assign mem_clk_en_o = q.mode == MODE_ACTIVE; // see R2
    assign periph_clk_en_o = awake(q.mode); // see R1 R2
    assign flash_pwr_o = awake(q.mode);
    assign periph_pwr_o = periph_clk_en_o; // see R4
    assign sram_pwr_o = awake(q.mode);
    assign sram_ret_o = q.mode == MODE_STANDBY; // see R4
    assign always_on_domain_pwr_o = !aon_lost(q.mode); // see R4 R8
    assign sensor_pwr_o = always_on_domain_pwr_o; // see R8
    assign brownout_detector_en_o = always_on_domain_pwr_o;
    assign io_latch_o = q.mode == MODE_STANDBY ||
        q.mode == MODE_SHUTDOWN || q.mode == MODE_HELD; // see R7 R8
    assign io_out_o = q.io; // see R8

    // Retention levels, see R14
    assign reg_ret_o = awake(q.mode) ?
        RET_FULL : (q.mode == MODE_STANDBY) ? RET_PARTIAL : RET_NONE;

    // Clock sources
    assign main_fast_clock_en_o = awake(q.mode); // see R17
    assign fast_crystal_osc_sel_o = q.clk_cfg[CLK_FAST_XTAL];
    assign medium_speed_clock_en_o = main_fast_clock_en_o ||
        (q.mode == MODE_STANDBY && q.clk_cfg[CLK_MED_STBY]); // see R15
    assign low_speed_clock_en_o = always_on_domain_pwr_o; // see R16
    assign slow_crystal_osc_sel_o = q.clk_cfg[CLK_SLOW_XTAL];
    // Wake path must never be gated off
    assign reset_pin_wake_en_o = 1'b1; // see R18

    assign mode_o = q.mode;
    assign irq_o = |(q.irq_st & q.irq_msk);

endmodule : power_mode_controller

// ===== dv/pmc_asserts.sv
`timescale 1ns/1ps
module pmc_asserts
    import pmc_pkg::*;
#(
    parameter int NPINS = 31
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Wake sources
    input wire logic rst_pin_n_i,
    input wire logic irq_event_i,
    input wire logic ext_wake_i,
    input wire logic rtc_event_i,
    input wire logic sensor_event_i,
    // Design outputs
    input wire logic [NPINS-1:0] io_out_o,
    input wire logic io_latch_o,
    input wire logic cpu_clk_en_o,
    input wire logic mem_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic flash_pwr_o,
    input wire logic sram_ret_o,
    input wire logic sram_pwr_o,
    input wire logic periph_pwr_o,
    input wire logic medium_speed_clock_en_o,
    input wire logic always_on_domain_pwr_o,
    input wire logic sensor_pwr_o,
    input wire logic [1:0] reg_ret_o,
    input wire logic main_fast_clock_en_o,
    input wire logic low_speed_clock_en_o,
    input wire logic reset_pin_wake_en_o,
    input wire pmc_pkg::mode_t mode_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    AST_ACTIVE_CLK: assert property (mode_o == MODE_ACTIVE |->
        cpu_clk_en_o && mem_clk_en_o && periph_clk_en_o
        && main_fast_clock_en_o)
        else $error("active clocks wrong");
    AST_IDLE_CLK: assert property (mode_o == MODE_IDLE |->
        !cpu_clk_en_o && !mem_clk_en_o && periph_clk_en_o)
        else $error("idle clocks wrong");
    AST_IDLE_WAKE: assert property (mode_o == MODE_IDLE &&
        irq_event_i && ce_i && rst_pin_n_i |=> mode_o == MODE_ACTIVE)
        else $error("idle did not wake");
    AST_STBY_STAY: assert property (mode_o == MODE_STANDBY &&
        !ext_wake_i && !rtc_event_i && !sensor_event_i && rst_pin_n_i
        |=> mode_o == MODE_STANDBY)
        else $error("standby left without cause");
    AST_STBY_DOM: assert property (mode_o == MODE_STANDBY |->
        always_on_domain_pwr_o && !flash_pwr_o && !cpu_clk_en_o
        && sram_ret_o && io_latch_o && reg_ret_o == RET_PARTIAL)
        else $error("standby domains wrong");
    AST_SHDN_OFF: assert property (mode_o == MODE_SHUTDOWN |->
        !always_on_domain_pwr_o && !sensor_pwr_o && !low_speed_clock_en_o
        && !medium_speed_clock_en_o && io_latch_o && reg_ret_o == RET_NONE)
        else $error("shutdown power wrong");
    AST_HELD_OFF: assert property (mode_o == MODE_HELD |->
        !main_fast_clock_en_o && !low_speed_clock_en_o
        && !medium_speed_clock_en_o && reg_ret_o == RET_NONE)
        else $error("held clocks wrong");
    AST_LOW_SUPPLY: assert property (mode_o != MODE_ACTIVE &&
        mode_o != MODE_IDLE |-> !periph_pwr_o && !sram_pwr_o && !mem_clk_en_o)
        else $error("low power supplies wrong");
    AST_IO_HOLD: assert property (io_latch_o && $past(io_latch_o)
        |-> $stable(io_out_o))
        else $error("latched io moved");
    AST_PIN_HELD: assert property (!rst_pin_n_i && ce_i
        |=> mode_o == MODE_HELD)
        else $error("reset pin not obeyed");
    AST_PIN_PATH: assert property (reset_pin_wake_en_o)
        else $error("reset pin wake off");
endmodule : pmc_asserts

bind power_mode_controller pmc_asserts #(.NPINS(NPINS)) pmc_asserts_i (.*);

// ===== dv/wake_event_model.sv
`timescale 1ns/1ps
module wake_event_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Bench command, bit 0 irq, 1 ext, 2 rtc, 3 sensor
    input wire logic [3:0] fire_i,
    // Events
    output logic irq_event_o,
    output logic ext_wake_o,
    output logic rtc_event_o,
    output logic sensor_event_o
);
    // Registered so events change only just after an edge
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {sensor_event_o, rtc_event_o, ext_wake_o, irq_event_o} <= 4'h0;
        end else begin
            {sensor_event_o, rtc_event_o, ext_wake_o, irq_event_o} <= fire_i;
        end
    end
endmodule : wake_event_model

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
    import pmc_pkg::*;
    logic sys_clk_i = 0, resetn_i = 0, ce_i = 1, psel_i = 0, penable_i = 0;
    logic pwrite_i = 0, pready_o, pslverr_o, rst_pin_n_i = 1;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, a, b;
    logic irq_event_i, ext_wake_i, rtc_event_i, sensor_event_i;
    logic debug_halt_i = 0, io_latch_o, irq_o, reset_pin_wake_en_o;
    logic [30:0] pin_i = 0, io_out_i = 0, io_out_o;
    logic cpu_clk_en_o, mem_clk_en_o, periph_clk_en_o, flash_pwr_o;
    logic sram_pwr_o, sram_ret_o, periph_pwr_o, always_on_domain_pwr_o;
    logic sensor_pwr_o, brownout_detector_en_o, main_fast_clock_en_o;
    logic fast_crystal_osc_sel_o, medium_speed_clock_en_o;
    logic low_speed_clock_en_o, slow_crystal_osc_sel_o;
    logic [1:0] reg_ret_o;
    logic [3:0] fire = 0;
    mode_t mode_o;
    int n_errors = 0, check_count = 0;

    always #12.5 sys_clk_i = ~sys_clk_i;

    power_mode_controller power_mode_controller_i (.*);
    wake_event_model wake_event_model_i (.sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i), .fire_i(fire), .irq_event_o(irq_event_i),
        .ext_wake_o(ext_wake_i), .rtc_event_o(rtc_event_i),
        .sensor_event_o(sensor_event_i));

    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] ad,
        input logic [31:0] d, output logic [31:0] rd, output logic er);
        int n;
        @(posedge sys_clk_i);
        psel_i <= 1;
        penable_i <= 0;
        pwrite_i <= w;
        paddr_i <= ad;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1;
        // Ready, data and error are all taken at the edge ending the access
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk_i);
            if (pready_o === 1'b1) break;
        end
        if (n == 20) begin
            n_errors++;
            conclude();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask : apb

    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, ad, d, r, e);
    endtask : wr

    task automatic rdv(input logic [11:0] ad, output logic [31:0] r);
        logic e;
        apb(1'b0, ad, 32'h0, r, e);
    endtask : rdv

    task automatic rdc(input logic [11:0] ad, input logic [31:0] exp,
        input logic eexp = 1'b0);
        logic [31:0] r;
        logic e;
        apb(1'b0, ad, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, eexp});
    endtask : rdc

    task automatic chkm(input mode_t e);
        #1;
        chk(32'(mode_o), 32'(e));
    endtask : chkm

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : cyc

    task automatic fire_ev(input int s);
        @(posedge sys_clk_i);
        fire <= 4'h1 << s;
        @(posedge sys_clk_i);
        fire <= 4'h0;
        cyc(3);
    endtask : fire_ev

    initial begin
        cyc(100000);
        n_errors++;
        conclude();
    end

    initial begin
        cyc(10);
        resetn_i <= 1;
        rdc(REG_RESET_CAUSE, 32'(CAUSE_POR));
        rdc(12'h3fc, 32'h0, 1'b1);
        wr(REG_IRQ_MASK, 32'h7);
        wr(REG_CTRL, 32'(REQ_IDLE));
        chkm(MODE_IDLE);
        chk({31'h0, irq_o}, 32'h0);
        // A low clock enable freezes the mode through an event
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        fire_ev(0);
        chkm(MODE_IDLE);
        @(posedge sys_clk_i);
        ce_i <= 1'b1;
        fire_ev(0);
        chkm(MODE_ACTIVE);
        chk({31'h0, irq_o}, 32'h1);
        rdc(REG_IRQ_STATUS, 32'h1);
        wr(REG_IRQ_MASK, 32'h6);
        #1;
        chk({31'h0, irq_o}, 32'h0);
        wr(REG_IRQ_STATUS, 32'h1);
        rdc(REG_IRQ_STATUS, 32'h0);
        wr(REG_WDT_LOAD, 32'h1000);
        wr(REG_WDT_CTRL, 32'h1);
        wr(REG_WDT_CTRL, 32'h0);
        rdc(REG_WDT_CTRL, 32'h1);
        rdv(REG_WDT_COUNT, a);
        cyc(200);
        rdv(REG_WDT_COUNT, b);
        chk({31'h0, b < a}, 32'h1);
        @(posedge sys_clk_i);
        debug_halt_i <= 1;
        rdv(REG_WDT_COUNT, a);
        cyc(200);
        rdv(REG_WDT_COUNT, b);
        chk(b, a);
        debug_halt_i <= 0;
        wr(REG_CLK_CFG, 32'h5);
        #1;
        chk({30'h0, slow_crystal_osc_sel_o, fast_crystal_osc_sel_o},
            32'h1);
        for (int s = 1; s < 4; s++) begin
            wr(REG_CTRL, 32'(REQ_STANDBY));
            chkm(MODE_STANDBY);
            chk({31'h0, medium_speed_clock_en_o}, 32'h1);
            rdv(REG_WDT_COUNT, a);
            cyc(200);
            io_out_i <= 31'(s);
            rdv(REG_WDT_COUNT, b);
            chk(b, a);
            fire_ev(0);
            chkm(MODE_STANDBY);
            chk({1'b0, io_out_o}, 32'(s - 1));
            fire_ev(s);
            chkm(MODE_ACTIVE);
            rdc(REG_CLK_CFG, 32'h5);
            rdc(REG_IRQ_STATUS, 32'h2);
            wr(REG_IRQ_STATUS, 32'h2);
        end
        @(posedge sys_clk_i);
        io_out_i <= 31'h05a5a5a5;
        wr(REG_WAKE_PIN_EN, 32'h8);
        wr(REG_CTRL, 32'(REQ_SHUTDOWN));
        chkm(MODE_SHUTDOWN);
        @(posedge sys_clk_i);
        io_out_i <= 31'h0;
        pin_i <= 31'h1;
        cyc(4);
        chk({1'b0, io_out_o}, 32'h05a5a5a5);
        chkm(MODE_SHUTDOWN);
        @(posedge sys_clk_i);
        pin_i <= 31'h9;
        cyc(4);
        chkm(MODE_ACTIVE);
        rdc(REG_RESET_CAUSE, 32'(CAUSE_SHDN_WAKE));
        rdc(REG_CLK_CFG, 32'h0);
        rdc(REG_WDT_CTRL, 32'h0);
        wr(REG_CLK_CFG, 32'h3);
        #1;
        chk({30'h0, slow_crystal_osc_sel_o, fast_crystal_osc_sel_o},
            32'h3);
        @(posedge sys_clk_i);
        rst_pin_n_i <= 0;
        cyc(3);
        chkm(MODE_HELD);
        @(posedge sys_clk_i);
        rst_pin_n_i <= 1;
        cyc(3);
        chkm(MODE_ACTIVE);
        rdc(REG_RESET_CAUSE, 32'(CAUSE_PIN));
        rdc(REG_CLK_CFG, 32'h0);
        conclude();
    end
endmodule : tb
